// >>> core/xie_pkg.sv
// Purpose: Constants and types for the exclusive-OR instruction execute block
// Assumes: 14-bit instruction words, 8-bit data, 7-bit file addresses
// Notes:   Opcode fields sit in the upper bits of the instruction word
package xie_pkg;

  // ==========================================================
  // Widths
  localparam int unsigned DATA_W = 8;
  localparam int unsigned ADDR_W = 7;
  localparam int unsigned INSN_W = 14;
  localparam int unsigned FILE_DEPTH = 128;

  // ==========================================================
  // Instruction fields
  localparam int unsigned LIT_OP_MSB  = 13;
  localparam int unsigned LIT_OP_LSB  = 8;
  localparam int unsigned FILE_OP_MSB = 13;
  localparam int unsigned FILE_OP_LSB = 8;
  localparam int unsigned DEST_BIT    = 7;

  localparam logic [5:0] OP_XOR_LITERAL_INTO_ACC = 6'h3A;
  localparam logic [5:0] OP_XOR_ACC_WITH_FILE    = 6'h06;

  localparam logic                DEST_ACC  = 1'h0;
  localparam logic [DATA_W-1:0]   ACC_RESET = 8'h00;
  localparam logic [DATA_W-1:0]   ZERO_BYTE = 8'h00;

  // ==========================================================
  // Four-phase instruction cycle, Gray coded
  typedef enum logic [1:0] {
    PH_Q1 = 2'h0,
    PH_Q2 = 2'h1,
    PH_Q3 = 2'h3,
    PH_Q4 = 2'h2
  } xie_phase_t;

endpackage

// >>> core/xie_file_ram.sv
// Purpose: File register storage for the execute block
// Assumes: One read and one write port, single clock
// Notes:   Read data comes out of a register one cycle after the address
`timescale 1ns/1ps
`default_nettype none
module xie_file_ram
  import xie_pkg::*;
(
  input  wire logic              clk,     // Core clock
  input  wire logic              we,      // Write strobe
  input  wire logic [ADDR_W-1:0] waddr,   // Write address
  input  wire logic [DATA_W-1:0] wdata,   // Write data
  input  wire logic [ADDR_W-1:0] raddr,   // Read address
  output logic      [DATA_W-1:0] rdata    // Registered read data
);

  logic [DATA_W-1:0] mem [FILE_DEPTH];

  // No reset: storage contents are undefined at power-up
  always_ff @(posedge clk)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end

endmodule
`default_nettype wire

// >>> core/xie_exec.sv
// Purpose: Decode and execute the two exclusive-OR instructions
// Assumes: Instruction word is held stable for a full four-phase cycle
// Notes:   Other opcodes pass through the cycle with no effect
// Function
// - Literal form XORs accumulator with 8-bit literal, result to accumulator.
// - Literal form: decode Q1, read literal Q2, process Q3, write Q4.
// - File form XORs accumulator with file register at 7-bit address.
// - File form: destination bit 0 writes accumulator, 1 writes back the file register.
`timescale 1ns/1ps
`default_nettype none
module xie_exec
  import xie_pkg::*;
(
  input  wire logic              clk,        // Core clock, 50 MHz
  input  wire logic              rst_b,      // Asynchronous reset, active low
  input  wire logic [INSN_W-1:0] insn,       // Current instruction word
  output logic      [DATA_W-1:0] acc,        // Working accumulator
  output logic                   zero_flag,  // Zero status flag
  output logic      [1:0]        phase,      // Current instruction phase
  output logic                   file_wr,    // Pulse: file register written in Q4
  output logic      [ADDR_W-1:0] file_addr,  // Address of the last file write
  output logic      [DATA_W-1:0] file_data   // Data of the last file write
);

  // ==========================================================
  // Reset release
  logic rst_meta_q;
  logic rst_sync_q;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  // ==========================================================
  // Phase sequencer
  xie_phase_t ph_q;
  xie_phase_t ph_d;

  always_comb
  begin
    case (ph_q)
      PH_Q1:   ph_d = PH_Q2;
      PH_Q2:   ph_d = PH_Q3;
      PH_Q3:   ph_d = PH_Q4;
      PH_Q4:   ph_d = PH_Q1;
      default: ph_d = PH_Q1;
    endcase
  end

  // ==========================================================
  // Decode and datapath
  logic              is_lit_q;
  logic              is_file_q;
  logic              dest_q;
  logic [ADDR_W-1:0] addr_q;
  logic [DATA_W-1:0] opnd_q;
  logic [DATA_W-1:0] res_q;
  logic [DATA_W-1:0] acc_q;
  logic              z_q;
  logic              fwr_q;
  logic [ADDR_W-1:0] faddr_q;
  logic [DATA_W-1:0] fdata_q;

  logic              is_lit_d;
  logic              is_file_d;
  logic              dest_d;
  logic [ADDR_W-1:0] addr_d;
  logic [DATA_W-1:0] opnd_d;
  logic [DATA_W-1:0] res_d;
  logic [DATA_W-1:0] acc_d;
  logic              z_d;
  logic              fwr_d;
  logic [ADDR_W-1:0] faddr_d;
  logic [DATA_W-1:0] fdata_d;
  logic [DATA_W-1:0] ram_rdata;

  // Read address is presented in Q1 so the registered RAM output is ready in Q2
  xie_file_ram u_ram (
    .clk   (clk),
    .we    (fwr_d),
    .waddr (faddr_d),
    .wdata (fdata_d),
    .raddr (insn[ADDR_W-1:0]),
    .rdata (ram_rdata)
  );

  always_comb
  begin
    is_lit_d  = is_lit_q;
    is_file_d = is_file_q;
    dest_d    = dest_q;
    addr_d    = addr_q;
    opnd_d    = opnd_q;
    res_d     = res_q;
    acc_d     = acc_q;
    z_d       = z_q;
    fwr_d     = 1'b0;
    faddr_d   = faddr_q;
    fdata_d   = fdata_q;
    case (ph_q)
      PH_Q1:
      begin
        is_lit_d  = (insn[LIT_OP_MSB:LIT_OP_LSB] == OP_XOR_LITERAL_INTO_ACC);
        is_file_d = (insn[FILE_OP_MSB:FILE_OP_LSB] == OP_XOR_ACC_WITH_FILE);
        dest_d    = insn[DEST_BIT];
        addr_d    = insn[ADDR_W-1:0];
      end
      PH_Q2:
      begin
        opnd_d = is_lit_q ? insn[DATA_W-1:0] : ram_rdata;
      end
      PH_Q3:
      begin
        res_d = acc_q ^ opnd_q;
      end
      PH_Q4:
      begin
        if (is_lit_q || is_file_q)
        begin
          z_d = (res_q == ZERO_BYTE);
          if (is_lit_q || dest_q == DEST_ACC)
          begin
            acc_d = res_q;
          end
          else
          begin
            fwr_d   = 1'b1;
            faddr_d = addr_q;
            fdata_d = res_q;
          end
        end
      end
      default:
      begin
        fwr_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_sync_q)
  begin
    if (!rst_sync_q)
    begin
      ph_q      <= PH_Q1;
      is_lit_q  <= 1'b0;
      is_file_q <= 1'b0;
      dest_q    <= 1'b0;
      addr_q    <= '0;
      opnd_q    <= ZERO_BYTE;
      res_q     <= ZERO_BYTE;
      acc_q     <= ACC_RESET;
      z_q       <= 1'b0;
      fwr_q     <= 1'b0;
      faddr_q   <= '0;
      fdata_q   <= ZERO_BYTE;
    end
    else
    begin
      ph_q      <= ph_d;
      is_lit_q  <= is_lit_d;
      is_file_q <= is_file_d;
      dest_q    <= dest_d;
      addr_q    <= addr_d;
      opnd_q    <= opnd_d;
      res_q     <= res_d;
      acc_q     <= acc_d;
      z_q       <= z_d;
      fwr_q     <= fwr_d;
      faddr_q   <= faddr_d;
      fdata_q   <= fdata_d;
    end
  end

  assign acc       = acc_q;
  assign zero_flag = z_q;
  assign phase     = ph_q;
  assign file_wr   = fwr_q;
  assign file_addr = faddr_q;
  assign file_data = fdata_q;

endmodule
`default_nettype wire

// >>> bench/xie_exec_props.sv
// Purpose: Port checks on the execute block
// Assumes: insn is held for each four-phase group
// Notes:   File data is unknown at start, so it is not compared
`timescale 1ns/1ps
`default_nettype none
module xie_exec_props
  import xie_pkg::*;
(
  input wire logic              clk,       // Core clock
  input wire logic              rst_b,     // Reset, active low
  input wire logic [INSN_W-1:0] insn,      // Instruction
  input wire logic [DATA_W-1:0] acc,       // Accumulator
  input wire logic              zero_flag, // Zero flag
  input wire logic [1:0]        phase,     // Phase
  input wire logic              file_wr,   // File write pulse
  input wire logic [ADDR_W-1:0] file_addr, // File write address
  input wire logic [DATA_W-1:0] file_data  // File write data
);
  // ======================================
  // Decode
  logic q4;
  logic lit;
  logic fil;
  assign q4 = phase == PH_Q4;
  assign lit = insn[LIT_OP_MSB:LIT_OP_LSB] == OP_XOR_LITERAL_INTO_ACC;
  assign fil = insn[FILE_OP_MSB:FILE_OP_LSB] == OP_XOR_ACC_WITH_FILE;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_phase_order: assert property (q4 |=> phase == PH_Q1 ##1 phase == PH_Q2 ##1 phase == PH_Q3)
    else $error("phase order broken");
  a_lit_result: assert property (q4 && lit |=> acc == ($past(acc) ^ $past(insn[DATA_W-1:0])))
    else $error("literal result wrong");
  a_lit_zero: assert property (q4 && lit |=> zero_flag == (acc == 8'h00))
    else $error("zero flag wrong");
  a_file_dest: assert property (q4 && fil && insn[DEST_BIT] |=> file_wr && $stable(acc)
    && file_addr == $past(insn[ADDR_W-1:0]))
    else $error("file write wrong");
  a_acc_dest: assert property (q4 && fil && !insn[DEST_BIT] |=> !file_wr)
    else $error("file written for dest 0");
  a_no_effect: assert property (q4 && !lit && !fil |=> !file_wr && $stable(acc))
    else $error("other opcode had effect");
endmodule
bind xie_exec xie_exec_props u_props (.clk(clk), .rst_b(rst_b), .insn(insn), .acc(acc),
  .zero_flag(zero_flag), .phase(phase), .file_wr(file_wr), .file_addr(file_addr),
  .file_data(file_data));
`default_nettype wire

// >>> bench/tb.sv
// Purpose: Self-checking bench for the execute block
// Assumes: One instruction per two groups, a blank group between
// Notes:   File form runs last; its unknown data would spoil later sums
`timescale 1ns/1ps
`default_nettype none
module tb;
  import xie_pkg::*;
  logic              clk = 1'b0;
  logic              rst_b = 1'b0;
  logic [INSN_W-1:0] insn = 14'h0000;
  logic [DATA_W-1:0] acc;
  logic [DATA_W-1:0] file_data;
  logic              zero_flag;
  logic              file_wr;
  logic [1:0]        phase;
  logic [ADDR_W-1:0] file_addr;
  int                miscompares = 0;
  int                total_checks = 0;
  int                cyc = 0;
  localparam logic [7:0] LITS [4] = '{8'hB5, 8'hAF, 8'h1A, 8'hFF};
  always #10 clk = ~clk;
  xie_exec u_dut (.clk(clk), .rst_b(rst_b), .insn(insn), .acc(acc), .zero_flag(zero_flag),
    .phase(phase), .file_wr(file_wr), .file_addr(file_addr), .file_data(file_data));
  // ======================================
  // Helpers
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Launch at the Q4 edge, blank the word once the group is done
  task automatic ex(input logic [INSN_W-1:0] i);
    while (phase !== 2'h2)
      @(negedge clk);
    @(posedge clk);
    insn <= i;
    repeat (4) @(posedge clk);
    insn <= 14'h0000;
    @(negedge clk);
  endtask
  // ======================================
  // Scenarios
  task automatic t_lit;
    logic [7:0] e;
    e = ACC_RESET;
    foreach (LITS[n])
    begin
      ex({OP_XOR_LITERAL_INTO_ACC, LITS[n]});
      e = e ^ LITS[n];
      chk("acc", e, acc);
      chk("zero", {7'h00, e == 8'h00}, {7'h00, zero_flag});
    end
  endtask
  task automatic t_other;
    ex(14'h3B55);
    chk("acc", 8'hFF, acc);
    ex(14'h0066);
    chk("wr", 8'h00, {7'h00, file_wr});
  endtask
  task automatic t_file;
    ex({OP_XOR_ACC_WITH_FILE, 1'b1, 7'h7F});
    chk("wr", 8'h01, {7'h00, file_wr});
    chk("addr", 8'h7F, {1'b0, file_addr});
    chk("acc", 8'hFF, acc);
    ex({OP_XOR_ACC_WITH_FILE, 1'b0, 7'h00});
    chk("wr", 8'h00, {7'h00, file_wr});
  endtask
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 1000)
    begin
      miscompares++;
      tally_and_finish;
    end
  end
  initial
  begin
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    @(negedge clk);
    t_lit;
    t_other;
    t_file;
    tally_and_finish;
  end
endmodule
`default_nettype wire
